// ==== verilog/flash_cfg2_defs.vh ====
`ifndef FLASH_CFG2_DEFS_VH
`define FLASH_CFG2_DEFS_VH

// ==================================================================
// Register addresses (full 32-bit register address)
`define ADDR_INTERFACE_MODE_SELECT 32'h00000000
`define ADDR_STROBE_OPTIONS 32'h00000200
`define ADDR_DUMMY_CYCLE_CONFIG 32'h00000300
`define ADDR_ERROR_PIN_CONDITION 32'h00000400
`define ADDR_CHECKSUM_PREAMBLE_CONFIG 32'h00000500
`define ADDR_CORRECTION_STATUS 32'h00000800
`define ADDR_FAIL_ADDRESS_BYTE0 32'h00000C00
`define ADDR_FAIL_ADDRESS_BYTE1 32'h00000D00
`define ADDR_FAIL_ADDRESS_BYTE2 32'h00000E00
`define ADDR_FAIL_ADDRESS_BYTE3 32'h00000F00
`define ADDR_DEFAULT_MODE_PARITY_OTP 32'h40000000
`define ADDR_CHECK_ERROR_STATUS 32'h80000000

// ==================================================================
// Field positions
`define STROBE_IN_SINGLE_RATE_EN_BIT 1
`define STROBE_PRECYCLE_BIT 0
`define CHECKSUM_CHUNK_SIZE_HI 6
`define CHECKSUM_CHUNK_SIZE_LO 5
`define CHECKSUM_OUTPUT_ENABLE_BIT 4
`define PREAMBLE_PATTERN_SELECT_BIT 0
`define FAIL_ADDRESS_VALID_BIT 7
`define PARITY_CHECK_ENABLE_N_BIT 3
`define CHECK_ERROR_FLAG_BIT 4

// ==================================================================
// Reset and fixed values
`define MODE_SINGLE_WIRE 2'h0
`define MODE_SINGLE_RATE_OCTAL 2'h1
`define MODE_DOUBLE_RATE_OCTAL 2'h2
`define MODE_FORBIDDEN 2'h3
`define DUMMY_CYCLE_CODE_RST 3'h0
`define DUMMY_CYCLES_MAX 5'h14
`define CHECKSUM_CHUNK_MIN_BYTES 8'h10
`define STATUS_CLEAR_VALUE 8'h00
`define FAIL_COUNT_MAX 4'hF
`define PREAMBLE_PATTERN_A 16'h349A
`define PREAMBLE_PATTERN_A_LINE3 16'h3514
`define PREAMBLE_PATTERN_B 16'h5555
`define OTP_FACTORY_DEFAULT 8'hFF

// ==================================================================
// Command codes and frame lengths (in serial bits)
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_WRITE_CONFIG_TWO 8'h72
`define CMD_READ_CONFIG_TWO 8'h71
`define FRAME_CMD_BITS 6'h08
`define FRAME_HDR_BITS 6'h28
`define FRAME_WRITE_BITS 6'h30

`endif

// ==== verilog/flash_cfg2_bank.v ====
// Function
// [RULE_01] Two-bit mode: 00 serial, 01 single-rate octal, 10 double-rate octal, 11 forbidden.
// [RULE_02] After reset the mode field loads from the stored default mode field.
// [RULE_03] One-time default mode field: 00 forbidden, 01 double, 10 single, 11 serial.
// [RULE_04] Volatile bit, default 0, enables strobe output in single-rate transfers.
// [RULE_05] Volatile bit adds one strobe pre-cycle before double-rate output.
// [RULE_06] Three-bit dummy-cycle code, default 000, sets read dummy cycles.
// [RULE_07] Two-bit code selects which correction events pull the error pin low.
// [RULE_08] Two-bit checksum chunk size: 16, 32, 64 or 128 bytes, default 16.
// [RULE_09] Checksum output pin driven only while its enable bit is 1.
// [RULE_10] Volatile pattern-select bit, default 0, picks the dummy-cycle preamble.
// [RULE_11] Valid flag set when a failing chunk address is recorded.
// [RULE_12] Three-bit correction status: single correct, two-bit detect, double program.
// [RULE_13] Four-bit failing chunk counter increments per failing read, saturates at 15.
// [RULE_14] Only the first failing address bits 25..4 kept, over four byte registers.
// [RULE_15] Writing 00 to the correction status register clears correction status.
// [RULE_16] One-time active-low parity enable bit, default 1 meaning disabled.
// [RULE_17] Check error flag set when a command or parity check fails.
// [RULE_18] Writing 00 to the check-error register clears the check error flag.
// [RULE_19] Host writes reserved bits at default and leaves undefined addresses alone.
// [RULE_20] Dummy codes 000..111 map to 20,18,16,14,12,10,8,6 cycles.
// [RULE_21] Pattern select 0 gives the mixed pattern, 1 gives alternating 0101.
// [RULE_22] Bank writes are accepted only with the write enable latch set.
// [RULE_23] Write enable latch clears when a bank write command completes.
// [RULE_24] Target register chosen by decoding the full 32-bit register address.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg2_defs.vh"

module flash_cfg2_bank #(
  parameter [7:0] OTP_FACTORY = `OTP_FACTORY_DEFAULT
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // Serial link from the host controller
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_si,
  output reg o_so,
  output reg o_so_oe_n,
  // Correction and check events from the array side
  input wire i_ecc_event,
  input wire [2:0] i_ecc_kind,
  input wire [25:4] i_ecc_chunk_addr,
  input wire i_check_fail,
  // Configuration outputs to the rest of the device
  output reg [1:0] o_interface_mode,
  output wire o_single_rate_octal_sel,
  output wire o_double_rate_octal_sel,
  output wire o_strobe_in_single_rate_en,
  output wire o_strobe_precycle,
  output reg [4:0] o_dummy_cycles,
  output reg o_error_indicator_pin_n,
  output reg [7:0] o_checksum_chunk_bytes,
  output wire o_checksum_output_enable,
  output reg [15:0] o_preamble_pattern,
  output reg [15:0] o_preamble_pattern_line3,
  output wire o_parity_check_enable,
  output wire o_write_enable_latch,
  output wire o_check_error_flag
);

  // ================================================================
  // State
  reg cs_s1_r, cs_s2_r, cs_s3_r;
  reg sclk_s1_r, sclk_s2_r, sclk_s3_r;
  reg si_s1_r, si_s2_r;
  reg [5:0] bit_cnt_r;
  reg [7:0] cmd_r;
  reg [31:0] addr_r;
  reg [7:0] wdata_r;
  reg [7:0] tx_r;
  reg write_enable_latch_r;
  reg mode_load_r;
  reg [1:0] strobe_opts_r;
  reg [2:0] dummy_cycle_code_r;
  reg [1:0] error_pin_condition_r;
  reg [1:0] checksum_chunk_size_r;
  reg checksum_output_enable_r;
  reg preamble_pattern_select_r;
  reg fail_address_valid_r;
  reg [2:0] correction_fail_status_r;
  reg [3:0] fail_chunk_counter_r;
  reg [25:4] fail_chunk_address_r;
  reg check_error_flag_r;
  reg [7:0] otp_r = OTP_FACTORY; // Non-volatile: survives reset
  reg [7:0] rdata_nxt;

  wire sclk_rise = sclk_s2_r & ~sclk_s3_r;
  wire sclk_fall = ~sclk_s2_r & sclk_s3_r;
  wire frame_end = cs_s2_r & ~cs_s3_r;
  wire frame_on = ~cs_s2_r;
  wire is_read = (cmd_r == `CMD_READ_CONFIG_TWO);
  wire bank_write = frame_end & (cmd_r == `CMD_WRITE_CONFIG_TWO) &
                    (bit_cnt_r == `FRAME_WRITE_BITS);
  wire bank_write_ok = bank_write & write_enable_latch_r; // see [RULE_22]
  wire clr_status = bank_write_ok & (addr_r == `ADDR_CORRECTION_STATUS) &
                    (wdata_r == `STATUS_CLEAR_VALUE);
  wire clr_check = bank_write_ok & (addr_r == `ADDR_CHECK_ERROR_STATUS) &
                   (wdata_r == `STATUS_CLEAR_VALUE);
  wire [1:0] default_double_single_n = otp_r[1:0];

  // ================================================================
  // Two-flop synchronisers for link pins
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= i_cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      sclk_s1_r <= i_sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      si_s1_r <= i_si;
      si_s2_r <= si_s1_r;
    end
  end

  // ================================================================
  // Read data mux over the full register address
  always @* begin
    rdata_nxt = 8'h00;
    case (addr_r) // see [RULE_24]
      `ADDR_INTERFACE_MODE_SELECT: rdata_nxt = {6'h00, o_interface_mode};
      `ADDR_STROBE_OPTIONS: rdata_nxt = {6'h00, strobe_opts_r};
      `ADDR_DUMMY_CYCLE_CONFIG: rdata_nxt = {5'h00, dummy_cycle_code_r};
      `ADDR_ERROR_PIN_CONDITION: rdata_nxt = {6'h00, error_pin_condition_r};
      `ADDR_CHECKSUM_PREAMBLE_CONFIG:
        rdata_nxt = {1'b0, checksum_chunk_size_r, checksum_output_enable_r, 3'h0,
                     preamble_pattern_select_r};
      `ADDR_CORRECTION_STATUS:
        rdata_nxt = {fail_address_valid_r, correction_fail_status_r, fail_chunk_counter_r};
      `ADDR_FAIL_ADDRESS_BYTE0: rdata_nxt = {fail_chunk_address_r[7:4], 4'h0}; // see [RULE_14]
      `ADDR_FAIL_ADDRESS_BYTE1: rdata_nxt = fail_chunk_address_r[15:8];
      `ADDR_FAIL_ADDRESS_BYTE2: rdata_nxt = fail_chunk_address_r[23:16];
      `ADDR_FAIL_ADDRESS_BYTE3: rdata_nxt = {6'h00, fail_chunk_address_r[25:24]};
      `ADDR_DEFAULT_MODE_PARITY_OTP: rdata_nxt = otp_r;
      `ADDR_CHECK_ERROR_STATUS: rdata_nxt = {3'h0, check_error_flag_r, 4'h0};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ================================================================
  // Serial frame: shift command, address and data; drive read data
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_cnt_r <= 6'h00;
      cmd_r <= 8'h00;
      addr_r <= 32'h00000000;
      wdata_r <= 8'h00;
      tx_r <= 8'h00;
      o_so <= 1'b0;
      o_so_oe_n <= 1'b1;
    end else if (!frame_on) begin
      bit_cnt_r <= 6'h00;
      o_so_oe_n <= 1'b1;
    end else begin
      if (sclk_rise) begin
        if (bit_cnt_r < `FRAME_CMD_BITS) begin
          cmd_r <= {cmd_r[6:0], si_s2_r};
        end else if (bit_cnt_r < `FRAME_HDR_BITS) begin
          addr_r <= {addr_r[30:0], si_s2_r};
        end else if (bit_cnt_r < `FRAME_WRITE_BITS) begin
          wdata_r <= {wdata_r[6:0], si_s2_r};
        end
        if (bit_cnt_r != 6'h3F) begin
          bit_cnt_r <= bit_cnt_r + 6'h01;
        end
      end
      // Fall ending the last address bit: address is whole, so load the addressed byte here
      if (sclk_fall && is_read && bit_cnt_r == `FRAME_HDR_BITS) begin
        o_so <= rdata_nxt[7];
        tx_r <= {rdata_nxt[6:0], rdata_nxt[7]};
        o_so_oe_n <= 1'b0;
      end else if (sclk_fall && is_read && bit_cnt_r > `FRAME_HDR_BITS) begin
        // Read byte repeats while the frame lasts
        o_so <= tx_r[7];
        tx_r <= {tx_r[6:0], tx_r[7]};
        o_so_oe_n <= 1'b0;
      end
    end
  end

  // ================================================================
  // Write enable latch
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      write_enable_latch_r <= 1'b0;
    end else if (frame_end && bit_cnt_r == `FRAME_CMD_BITS) begin
      if (cmd_r == `CMD_WRITE_ENABLE) begin
        write_enable_latch_r <= 1'b1;
      end else if (cmd_r == `CMD_WRITE_DISABLE) begin
        write_enable_latch_r <= 1'b0;
      end
    end else if (bank_write) begin
      write_enable_latch_r <= 1'b0; // see [RULE_23]
    end
  end

  // ================================================================
  // Volatile configuration registers
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_load_r <= 1'b1;
      o_interface_mode <= `MODE_SINGLE_WIRE;
      strobe_opts_r <= 2'h0;
      dummy_cycle_code_r <= `DUMMY_CYCLE_CODE_RST;
      error_pin_condition_r <= 2'h0;
      checksum_chunk_size_r <= 2'h0;
      checksum_output_enable_r <= 1'b0;
      preamble_pattern_select_r <= 1'b0;
    end else begin
      mode_load_r <= 1'b0;
      if (mode_load_r) begin
        o_interface_mode <= ~default_double_single_n; // see [RULE_02]
      end else if (bank_write_ok) begin
        case (addr_r) // see [RULE_24]
          `ADDR_INTERFACE_MODE_SELECT: o_interface_mode <= wdata_r[1:0]; // see [RULE_01]
          `ADDR_STROBE_OPTIONS: strobe_opts_r <= wdata_r[1:0];
          `ADDR_DUMMY_CYCLE_CONFIG: dummy_cycle_code_r <= wdata_r[2:0]; // see [RULE_06]
          `ADDR_ERROR_PIN_CONDITION: error_pin_condition_r <= wdata_r[1:0];
          `ADDR_CHECKSUM_PREAMBLE_CONFIG: begin
            checksum_chunk_size_r <=
              wdata_r[`CHECKSUM_CHUNK_SIZE_HI:`CHECKSUM_CHUNK_SIZE_LO];
            checksum_output_enable_r <= wdata_r[`CHECKSUM_OUTPUT_ENABLE_BIT];
            preamble_pattern_select_r <= wdata_r[`PREAMBLE_PATTERN_SELECT_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // ================================================================
  // One-time default mode and parity enable: bits only go 1 to 0
  always @(posedge i_clk_sys) begin
    if (bank_write_ok && addr_r == `ADDR_DEFAULT_MODE_PARITY_OTP) begin
      otp_r <= otp_r & {4'hF, wdata_r[3], 1'b1, wdata_r[1:0]}; // see [RULE_03] [RULE_16]
    end
  end

  // ================================================================
  // Correction status, counter and first failing address
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fail_address_valid_r <= 1'b0;
      correction_fail_status_r <= 3'h0;
      fail_chunk_counter_r <= 4'h0;
      fail_chunk_address_r <= 22'h000000;
    end else begin
      if (clr_status) begin // see [RULE_15]
        fail_address_valid_r <= 1'b0;
        correction_fail_status_r <= 3'h0;
        fail_chunk_counter_r <= 4'h0;
      end
      // Event in the clearing cycle still lands
      if (i_ecc_event && i_ecc_kind != 3'h0) begin
        correction_fail_status_r <= (clr_status ? 3'h0 : correction_fail_status_r) |
                                    i_ecc_kind; // see [RULE_12]
        if (clr_status) begin
          fail_chunk_counter_r <= 4'h1;
        end else if (fail_chunk_counter_r != `FAIL_COUNT_MAX) begin
          fail_chunk_counter_r <= fail_chunk_counter_r + 4'h1; // see [RULE_13]
        end
        if ((!fail_address_valid_r || clr_status) && (i_ecc_kind[1:0] != 2'h0)) begin
          fail_address_valid_r <= 1'b1; // see [RULE_11]
          fail_chunk_address_r <= i_ecc_chunk_addr; // see [RULE_14]
        end
      end
    end
  end

  // ================================================================
  // Command or parity check error flag
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      check_error_flag_r <= 1'b0;
    end else if (i_check_fail) begin
      check_error_flag_r <= 1'b1; // see [RULE_17]
    end else if (clr_check) begin
      check_error_flag_r <= 1'b0; // see [RULE_18]
    end
  end

  // ================================================================
  // Registered decoded outputs
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dummy_cycles <= `DUMMY_CYCLES_MAX;
      o_checksum_chunk_bytes <= `CHECKSUM_CHUNK_MIN_BYTES;
      o_preamble_pattern <= `PREAMBLE_PATTERN_A;
      o_preamble_pattern_line3 <= `PREAMBLE_PATTERN_A_LINE3;
      o_error_indicator_pin_n <= 1'b1;
    end else begin
      o_dummy_cycles <= `DUMMY_CYCLES_MAX - {1'b0, dummy_cycle_code_r, 1'b0}; // see [RULE_20]
      o_checksum_chunk_bytes <= `CHECKSUM_CHUNK_MIN_BYTES << checksum_chunk_size_r; // see [RULE_08]
      if (preamble_pattern_select_r) begin // see [RULE_10]
        o_preamble_pattern <= `PREAMBLE_PATTERN_B; // see [RULE_21]
        o_preamble_pattern_line3 <= `PREAMBLE_PATTERN_B;
      end else begin
        o_preamble_pattern <= `PREAMBLE_PATTERN_A; // see [RULE_21]
        o_preamble_pattern_line3 <= `PREAMBLE_PATTERN_A_LINE3;
      end
      case (error_pin_condition_r) // see [RULE_07]
        2'h0: o_error_indicator_pin_n <= ~(correction_fail_status_r[1] |
                                           correction_fail_status_r[2]);
        2'h1: o_error_indicator_pin_n <= ~(|correction_fail_status_r);
        2'h2: o_error_indicator_pin_n <= ~correction_fail_status_r[1];
        default: o_error_indicator_pin_n <= ~(correction_fail_status_r[0] |
                                              correction_fail_status_r[1]);
      endcase
    end
  end

  // Plain decodes of stored fields
  assign o_single_rate_octal_sel = (o_interface_mode == `MODE_SINGLE_RATE_OCTAL);
  assign o_double_rate_octal_sel = (o_interface_mode == `MODE_DOUBLE_RATE_OCTAL);
  assign o_strobe_in_single_rate_en = strobe_opts_r[`STROBE_IN_SINGLE_RATE_EN_BIT]; // see [RULE_04]
  assign o_strobe_precycle = strobe_opts_r[`STROBE_PRECYCLE_BIT]; // see [RULE_05]
  assign o_checksum_output_enable = checksum_output_enable_r; // see [RULE_09]
  assign o_parity_check_enable = ~otp_r[`PARITY_CHECK_ENABLE_N_BIT]; // see [RULE_16]
  assign o_write_enable_latch = write_enable_latch_r;
  assign o_check_error_flag = check_error_flag_r;

endmodule
`default_nettype wire

// ==== verif/flash_cfg2_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Host controller: link mode 0, MSB first, clock still between frames
module flash_cfg2_host (
  // Link to the device
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si,
  input wire logic i_so
);
  // Idle levels
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end

  // One frame: n bits out, then one byte in when it is a 40-bit read
  task automatic xfer(input logic [47:0] bits, input int n, output logic [7:0] q);
    q = 8'h00;
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_si = bits[47-i];
      #100 o_sclk = 1'b1;
      #100 o_sclk = 1'b0;
    end
    o_si = ~o_si; // No stale bit left on the line
    if (bits[47:40] == 8'h71 && n == 40) begin
      for (int i = 0; i < 8; i++) begin
        #100 o_sclk = 1'b1;
        #50 q[7-i] = i_so;
        #50 o_sclk = 1'b0;
      end
    end
    #100 o_cs_n = 1'b1;
    #250;
  endtask
endmodule
`default_nettype wire

// ==== verif/flash_cfg2_bank_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Port checker for the register bank
module flash_cfg2_bank_asserts (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Watched inputs
  input wire logic i_cs_n,
  input wire logic i_ecc_event,
  input wire logic [2:0] i_ecc_kind,
  input wire logic i_check_fail,
  // Watched outputs
  input wire logic [1:0] o_interface_mode,
  input wire logic o_single_rate_octal_sel,
  input wire logic o_double_rate_octal_sel,
  input wire logic [4:0] o_dummy_cycles,
  input wire logic o_error_indicator_pin_n,
  input wire logic [7:0] o_checksum_chunk_bytes,
  input wire logic [15:0] o_preamble_pattern,
  input wire logic [15:0] o_preamble_pattern_line3,
  input wire logic o_write_enable_latch,
  input wire logic o_check_error_flag
);
  default clocking dclk @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  a_mode_decode: assert property (o_double_rate_octal_sel == (o_interface_mode == 2'h2)
    && o_single_rate_octal_sel == (o_interface_mode == 2'h1))
    else $error("mode decode wrong");
  a_dummy_range: assert property (o_dummy_cycles inside
    {5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14})
    else $error("dummy count off table");
  a_chunk_size: assert property (o_checksum_chunk_bytes inside
    {8'h10, 8'h20, 8'h40, 8'h80})
    else $error("chunk size off table");
  a_pattern_pair: assert property ({o_preamble_pattern, o_preamble_pattern_line3} inside
    {32'h349A3514, 32'h55555555})
    else $error("preamble pair wrong");
  a_check_set: assert property (i_check_fail |=> o_check_error_flag)
    else $error("check flag not set");
  a_two_bit_pin: assert property (i_ecc_event && i_ecc_kind[1] |=> ##1 !o_error_indicator_pin_n)
    else $error("error pin not low");
  a_cfg_on_close: assert property ($changed(o_dummy_cycles) || $changed(o_checksum_chunk_bytes)
    || $changed(o_preamble_pattern) |-> i_cs_n)
    else $error("config changed in frame");
  a_wel_rise: assert property ($rose(o_write_enable_latch) |-> i_cs_n)
    else $error("latch set in frame");
  a_flag_clear: assert property ($fell(o_check_error_flag) |-> i_cs_n)
    else $error("flag cleared in frame");
endmodule

bind flash_cfg2_bank flash_cfg2_bank_asserts u_chk (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n), .i_ecc_event(i_ecc_event),
  .i_ecc_kind(i_ecc_kind), .i_check_fail(i_check_fail), .o_interface_mode(o_interface_mode),
  .o_single_rate_octal_sel(o_single_rate_octal_sel),
  .o_double_rate_octal_sel(o_double_rate_octal_sel), .o_dummy_cycles(o_dummy_cycles),
  .o_error_indicator_pin_n(o_error_indicator_pin_n),
  .o_checksum_chunk_bytes(o_checksum_chunk_bytes), .o_preamble_pattern(o_preamble_pattern),
  .o_preamble_pattern_line3(o_preamble_pattern_line3),
  .o_write_enable_latch(o_write_enable_latch), .o_check_error_flag(o_check_error_flag));
`default_nettype wire

// ==== verif/flash_cfg2_bank_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Bench for the register bank
module flash_cfg2_bank_bench;
  logic i_clk_sys, i_sys_rst, i_ecc_event, i_check_fail;
  logic [2:0] i_ecc_kind;
  logic [25:4] i_ecc_chunk_addr;
  logic [7:0] q;
  wire i_cs_n, i_sclk, i_si, o_so, o_double_rate_octal_sel, o_error_indicator_pin_n;
  wire o_so_oe_n, o_single_rate_octal_sel, o_strobe_in_single_rate_en, o_strobe_precycle;
  wire o_checksum_output_enable, o_parity_check_enable, o_write_enable_latch, o_check_error_flag;
  wire [1:0] o_interface_mode;
  wire [4:0] o_dummy_cycles;
  wire [7:0] o_checksum_chunk_bytes;
  wire [15:0] o_preamble_pattern, o_preamble_pattern_line3;
  int err_total, cmp_count;
  // Address, write data, expected readback
  localparam logic [47:0] ROWS [7] = '{{32'h200, 8'h03, 8'h03}, {32'h300, 8'h05, 8'h05},
    {32'h400, 8'h02, 8'h02}, {32'h500, 8'h71, 8'h71}, {32'h0, 8'h01, 8'h01},
    {32'h100, 8'h5A, 8'h00}, {32'h01000300, 8'h33, 8'h00}};
  localparam logic [7:0] FA [4] = '{8'hE0, 8'hCD, 8'hAB, 8'h02};
  localparam logic [7:0] FM [4] = '{8'hF0, 8'hFF, 8'hFF, 8'h03};

  flash_cfg2_host host (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_si(i_si), .i_so(o_so));
  flash_cfg2_bank dut (.i_clk_sys, .i_sys_rst, .i_cs_n, .i_sclk, .i_si, .o_so, .o_so_oe_n,
    .i_ecc_event, .i_ecc_kind, .i_ecc_chunk_addr, .i_check_fail, .o_interface_mode,
    .o_single_rate_octal_sel, .o_double_rate_octal_sel, .o_strobe_in_single_rate_en,
    .o_strobe_precycle, .o_dummy_cycles, .o_error_indicator_pin_n, .o_checksum_chunk_bytes,
    .o_checksum_output_enable, .o_preamble_pattern, .o_preamble_pattern_line3,
    .o_parity_check_enable, .o_write_enable_latch, .o_check_error_flag);

  // ================================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input bit en = 1'b1);
    if (en) host.xfer({8'h06, 40'h0}, 8, q);
    host.xfer({8'h72, a, d}, 48, q);
  endtask
  task automatic rd(input logic [31:0] a);
    host.xfer({8'h71, a, 8'h00}, 40, q);
  endtask
  task automatic ev(input logic [2:0] k, input logic [25:4] a);
    @(negedge i_clk_sys);
    i_ecc_event = 1'b1;
    i_ecc_kind = k;
    i_ecc_chunk_addr = a;
    @(negedge i_clk_sys);
    i_ecc_event = 1'b0;
    repeat (3) @(negedge i_clk_sys);
  endtask
  task automatic do_reset;
    @(negedge i_clk_sys);
    i_sys_rst = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    repeat (3) @(negedge i_clk_sys);
  endtask
  task automatic rst_chk(input logic [1:0] m, input logic p);
    chk("reset outs", {m, 1'b0, 1'b0, p, 1'b0, 1'b1, 5'h14, 8'h10}, {12'h0, o_interface_mode,
      o_write_enable_latch, o_check_error_flag, o_parity_check_enable,
      o_checksum_output_enable, o_error_indicator_pin_n, o_dummy_cycles,
      o_checksum_chunk_bytes});
    chk("reset pattern", 32'h349A3514, {o_preamble_pattern, o_preamble_pattern_line3});
  endtask
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Clock
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // Watchdog
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end

  // ================================================================
  // Main sequence
  initial begin
    {i_sys_rst, i_ecc_event, i_check_fail, i_ecc_kind, i_ecc_chunk_addr} = '0;
    i_sys_rst = 1'b1;
    do_reset();
    rst_chk(2'h0, 1'b0);
    foreach (ROWS[i]) begin
      wr(ROWS[i][47:16], ROWS[i][15:8]);
      rd(ROWS[i][47:16]);
      chk("row readback", 32'(ROWS[i][7:0]), 32'(q));
    end
    chk("strobe bits", 32'h3, 32'({o_strobe_in_single_rate_en, o_strobe_precycle}));
    rd(32'h300);
    chk("alias kept", 32'h05, 32'(q));
    chk("oe idle", 32'h1, 32'(o_so_oe_n));
    // Short frame, undefined target, missing latch
    host.xfer({8'h06, 40'h0}, 8, q);
    chk("latch set", 32'h1, 32'(o_write_enable_latch));
    host.xfer({8'h72, 32'h300, 8'h07}, 47, q);
    wr(32'h100, 8'h5A);
    chk("latch cleared", 32'h0, 32'(o_write_enable_latch));
    wr(32'h300, 8'h07, 1'b0);
    chk("no latch", 32'h0A, 32'(o_dummy_cycles));
    for (int m = 0; m < 4; m++) begin
      wr(32'h0, 8'(m));
      chk("mode", 32'(m) | ((m == 2) ? 32'h4 : 32'h0) | ((m == 1) ? 32'h8 : 32'h0),
        32'({o_single_rate_octal_sel, o_double_rate_octal_sel, o_interface_mode}));
    end
    for (int c = 0; c < 8; c++) begin
      wr(32'h300, 8'(c));
      chk("dummy", 32'(20 - 2 * c), 32'(o_dummy_cycles));
    end
    for (int s = 0; s < 4; s++) begin
      wr(32'h500, {1'b0, 2'(s), s[0], 3'h0, s[1]});
      chk("chunk", 32'(16 << s) | (s[0] ? 32'h100 : 32'h0),
        32'({o_checksum_output_enable, o_checksum_chunk_bytes}));
      chk("pattern", s[1] ? 32'h55555555 : 32'h349A3514,
        {o_preamble_pattern, o_preamble_pattern_line3});
    end
    // Correction events and first address
    ev(3'h1, 22'h2ABCDE);
    ev(3'h2, 22'h155555);
    wr(32'hD00, 8'h00);
    rd(32'h800);
    chk("ecc status", 32'hB2, 32'(q));
    for (int i = 0; i < 4; i++) begin
      rd(32'hC00 + 32'(i) * 32'h100);
      chk("fail addr", 32'(FA[i]), 32'(q & FM[i]));
    end
    repeat (14) ev(3'h1, 22'h3FFFFF);
    wr(32'h800, 8'h55);
    rd(32'h800);
    chk("saturated", 32'hBF, 32'(q));
    wr(32'h800, 8'h00);
    rd(32'h800);
    chk("status clear", 32'h00, 32'(q));
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        wr(32'h400, 8'(c));
        wr(32'h800, 8'h00);
        ev(k ? 3'h4 : 3'h1, 22'h0);
        chk("error pin", k ? 32'(c[1]) : 32'(!c[0]), 32'(o_error_indicator_pin_n));
      end
    end
    // Check flag set and clear
    @(negedge i_clk_sys);
    i_check_fail = 1'b1;
    @(negedge i_clk_sys);
    i_check_fail = 1'b0;
    rd(32'h80000000);
    chk("check flag", 32'h10, 32'(q & 8'h10));
    wr(32'h80000000, 8'h00);
    chk("flag clear", 32'h0, 32'(o_check_error_flag));
    // Stored default mode and parity enable survive a reset
    wr(32'h40000000, 8'hF5);
    rd(32'h40000000);
    chk("stored byte", 32'hF5, 32'(q));
    do_reset();
    rst_chk(2'h2, 1'b1);
    chk("double sel", 32'h1, 32'(o_double_rate_octal_sel));
    finish_test();
  end
endmodule
`default_nettype wire
